/* File: rtl/multi_frame_rx_buffer.sv */
`timescale 1ns/1ps

// Functional notes
// (RL1) Multi-frame only with enable bit and transceive
// (RL2) Receiver re-armed after each completed frame
// (RL3) Buffer split into 32-byte sub-buffers
// (RL4) At most eight frames per cycle
// (RL5) Frame n starts at byte 32 times n
// (RL6) At most 28 payload bytes per frame
// (RL7) Status word at bytes 28 to 31
// (RL8) Status: count, flags, combined flag, length
// (RL9) Reserved status bits written as zero
// (RL10) Host ignores bytes between payload and status
// (RL11) Good frame: data stored, no flags
// (RL12) Integrity fail: data, combined and payload flags
// (RL13) Length over 28: status only, length flag
// (RL14) Short frame: data stored, short flag set
// (RL15) Receive event flag set for every frame
// (RL16) Host may mask event, use timeout
// (RL17) Frame count field updated as frames end
// (RL18) After eighth frame go to wait-send
// (RL19) Idle command stops reception at once
// (RL20) Frame count cleared at new cycle start
// (RL21) Receiver off gap at least two RF cycles
// (RL22) Status word layout fixed and published
module multi_frame_rx_buffer
  import mfr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] rx_byte,
  input wire logic rx_byte_valid,
  input wire logic rx_frame_end,
  input wire logic rx_crc_ok,
  input wire logic rx_collision,
  output logic rx_enable,
  output logic wait_send
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    rx_state_t st;
    logic multi_frame_receive;
    logic multi_run;
    logic [3:0] nframes;
    logic [5:0] cnt;
    logic [7:0] len;
    logic crc_bad;
    logic coll;
    logic [6:0] gap;
    logic rx_event;
    logic rx_enable;
    logic mem_we;
    logic [5:0] mem_addr;
    logic [3:0] mem_be;
    logic [31:0] mem_wdata;
    logic awready;
    logic aw_have;
    logic [11:0] aw_addr;
    logic wready;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t q;
  state_t d;
  logic [31:0] buf_mem [64];
  logic wr_fire;
  logic cmd_start;
  logic cmd_idle;
  logic [7:0] len_now;
  logic [31:0] status_word;

  assign wr_fire = q.aw_have && q.w_have && !q.bvalid;
  assign cmd_start = wr_fire && q.aw_addr == A_CMD && q.w_strb[0] &&
                     q.w_data[CMD_START_BIT];
  assign cmd_idle = wr_fire && q.aw_addr == A_CMD && q.w_strb[0] &&
                    q.w_data[CMD_IDLE_BIT];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.mem_we = 1'b0;
    len_now = (q.cnt == 6'h00) ? rx_byte : q.len;
    // (RL8) (RL9) (RL22) Fixed layout, rest zero
    status_word = '0;
    status_word[SW_CNT_LSB +: 6] = q.cnt;
    if (q.len > MAX_LEN_BYTE) begin
      // (RL13) Over-length frame flag
      status_word[SW_LEN_BIT] = 1'b1;
    end else begin
      // (RL11) (RL12) Clean or integrity flags
      status_word[SW_PAYLOAD_BIT] = q.crc_bad;
      // (RL14) Short frame flags
      status_word[SW_SHORT_BIT] = {2'h0, q.cnt} < q.len;
      status_word[SW_LEN_BIT] = {2'h0, q.cnt} < q.len;
      status_word[SW_COLL_BIT] = q.coll;
      status_word[SW_COMB_BIT] = q.crc_bad || q.coll ||
                                 ({2'h0, q.cnt} < q.len);
    end

    // Write channels taken in either order
    if (awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = awaddr;
      d.awready = 1'b0;
    end
    if (wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.w_data = wdata;
      d.w_strb = wstrb;
      d.wready = 1'b0;
    end
    if (wr_fire) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = (q.aw_addr[11:4] == 8'h00) ? RESP_OKAY : RESP_SLVERR;
      if (q.aw_addr == A_CTRL && q.w_strb[0]) begin
        d.multi_frame_receive = q.w_data[CTRL_MFR_BIT];
      end
      // Cleared here, so a set below still wins
      if (q.aw_addr == A_EVENT && q.w_strb[0] && q.w_data[EVT_RX_BIT]) begin
        d.rx_event = 1'b0;
      end
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end

    // Read channel
    if (arvalid && q.arready) begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = '0;
      if (araddr[11:8] == BUF_PAGE) begin
        d.rdata = buf_mem[araddr[7:2]];
      end else if (araddr[11:2] == A_CTRL[11:2]) begin
        d.rdata[CTRL_MFR_BIT] = q.multi_frame_receive;
      end else if (araddr[11:2] == A_CMD[11:2]) begin
        d.rdata = '0;
      end else if (araddr[11:2] == A_RX_STATUS[11:2]) begin
        d.rdata[STAT_NFR_LSB +: 4] = q.nframes;
        d.rdata[STAT_ST_LSB +: 5] = q.st;
      end else if (araddr[11:2] == A_EVENT[11:2]) begin
        d.rdata[EVT_RX_BIT] = q.rx_event;
      end else begin
        d.rresp = RESP_SLVERR;
      end
    end
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end

    // Receive sequencer
    unique case (q.st)
      st_idle, st_wait_send: begin
        if (cmd_start) begin
          // (RL1) Enable bit sampled at transceive start
          d.multi_run = q.multi_frame_receive;
          // (RL20) Count cleared on new cycle
          d.nframes = 4'h0;
          d.cnt = 6'h00;
          d.len = 8'h00;
          d.crc_bad = 1'b0;
          d.coll = 1'b0;
          d.rx_enable = 1'b1;
          d.st = st_recv;
        end
      end
      st_recv: begin
        if (rx_byte_valid) begin
          if (q.cnt == 6'h00) begin
            d.len = rx_byte;
          end
          if (q.cnt != 6'h3f) begin
            d.cnt = q.cnt + 6'h01;
          end
          // (RL6) Payload capped, over-length dropped
          if (len_now <= MAX_LEN_BYTE && q.cnt < MAX_PAYLOAD) begin
            d.mem_we = 1'b1;
            // (RL5) Sub-buffer base from frame count
            d.mem_addr = {q.nframes[2:0], q.cnt[4:2]};
            d.mem_be = 4'h1 << q.cnt[1:0];
            d.mem_wdata = {4{rx_byte}};
          end
        end
        if (rx_frame_end) begin
          d.crc_bad = !rx_crc_ok;
          d.coll = rx_collision;
          d.rx_enable = 1'b0;
          d.st = st_write_status;
        end
      end
      st_write_status: begin
        // (RL7) Status in last word of sub-buffer
        d.mem_we = 1'b1;
        d.mem_addr = {q.nframes[2:0], STATUS_WORD_IDX};
        d.mem_be = 4'hf;
        d.mem_wdata = status_word;
        // (RL15) Event per frame
        d.rx_event = 1'b1;
        // (RL17) Frame count published
        d.nframes = q.nframes + 4'h1;
        // (RL4) (RL18) Eighth frame ends cycle
        if (q.multi_run && q.nframes != MAX_FRAMES - 4'h1) begin
          d.gap = 7'h00;
          d.st = st_gap;
        end else begin
          d.st = st_wait_send;
        end
      end
      st_gap: begin
        // (RL21) Receiver held off for gap
        if (q.gap == GAP_CYCLES - 7'h01) begin
          // (RL2) Receiver re-armed
          d.rx_enable = 1'b1;
          d.cnt = 6'h00;
          d.len = 8'h00;
          d.crc_bad = 1'b0;
          d.coll = 1'b0;
          d.st = st_recv;
        end else begin
          d.gap = q.gap + 7'h01;
        end
      end
      default: begin
        d.rx_enable = 1'b0;
        d.st = st_idle;
      end
    endcase

    // (RL19) Idle command aborts reception
    if (cmd_idle) begin
      d.rx_enable = 1'b0;
      d.mem_we = 1'b0;
      d.st = st_idle;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= st_idle;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // (RL3) Byte-lane writes into the shared buffer
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      if (q.mem_we && q.mem_be[i]) begin
        buf_mem[q.mem_addr][8*i +: 8] <= q.mem_wdata[8*i +: 8];
      end
    end
  end

  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign rx_enable = q.rx_enable;
  assign wait_send = q.st[ST_WAIT_SEND_BIT];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // (RL1) Single frame without enable
  chk_single_frame: assert property ( // RL1
    (q.st == st_write_status && !q.multi_run && !cmd_idle)
      |=> q.st == st_wait_send)
    else $error("single frame did not end in wait-send");
  // (RL2) Rearm after gap
  chk_rearm_after: assert property ( // RL2
    (q.st == st_write_status && q.multi_run && q.nframes < 4'h7 &&
     !cmd_idle) |-> ##[7:8] q.rx_enable)
    else $error("receiver not re-armed after frame");
  // (RL4) Frame count bound
  chk_frame_limit: assert property (q.nframes <= MAX_FRAMES) // RL4
    else $error("more than eight frames counted");
  // (RL6) Payload lanes below status
  chk_payload_cap: assert property ( // RL6
    (q.mem_we && q.mem_be != 4'hf) |-> q.mem_addr[2:0] != 3'h7)
    else $error("payload byte written into status word");
  // (RL7) Status write position
  chk_status_word: assert property ( // RL7
    (q.st == st_write_status && !cmd_idle) |=>
      (q.mem_we && q.mem_be == 4'hf && q.mem_addr[2:0] == 3'h7 &&
       q.mem_wdata[31:13] == 19'h0))
    else $error("status word not written to bytes 28 to 31");
  // (RL13) Over-length frame not stored
  chk_overlong_drop: assert property ( // RL13
    (q.st == st_recv && rx_byte_valid && len_now > MAX_LEN_BYTE) |=> !q.mem_we)
    else $error("over-length payload byte stored");
  // (RL15) Event set per frame
  chk_event_set: assert property ( // RL15
    (q.st == st_write_status && !cmd_idle) |=> q.rx_event)
    else $error("receive event not set");
  // (RL18) Eighth frame stops cycle
  chk_eighth_frame: assert property ( // RL18
    (q.st == st_write_status && q.nframes == 4'h7 && !cmd_idle)
      |=> (wait_send && q.nframes == 4'h8 && !q.rx_enable))
    else $error("eighth frame did not stop the cycle");
  // (RL19) Idle abort
  chk_idle_abort: assert property ( // RL19
    cmd_idle |=> (q.st == st_idle && !q.rx_enable))
    else $error("idle command did not stop reception");
  // (RL20) Count clear
  chk_count_clear: assert property ( // RL20
    (cmd_start && !cmd_idle && (q.st == st_idle || wait_send))
      |=> (q.nframes == 4'h0 && q.rx_enable))
    else $error("frame count not cleared at start");
  // (RL21) Least receiver-off gap
  chk_rearm_gap: assert property ( // RL21
    $fell(q.rx_enable) |-> (!q.rx_enable) [*7])
    else $error("receiver re-armed too early");
  cov_full_cycle: cover property (
    q.st == st_write_status && q.nframes == 4'h7);
  cov_length_fault: cover property (
    q.mem_we && q.mem_be == 4'hf && q.mem_wdata[SW_LEN_BIT]);
  cov_idle_abort: cover property (cmd_idle && q.st == st_recv);

endmodule // multi_frame_rx_buffer

/* File: rtl/mfr_pkg.sv */
package mfr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned RF_CYCLE_PS = 73746;
  localparam int unsigned GAP_RF_CYCLES = 2;
  localparam int unsigned GAP_MIN_PS = GAP_RF_CYCLES * RF_CYCLE_PS;
  // Least time, so round up
  localparam int unsigned GAP_CYC_INT =
    (GAP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [6:0] GAP_CYCLES = GAP_CYC_INT[6:0];

  // ----------------------------------------------------------------
  // Buffer geometry
  // ----------------------------------------------------------------
  localparam logic [3:0] MAX_FRAMES = 4'h8;
  localparam logic [5:0] MAX_PAYLOAD = 6'h1c;
  localparam logic [7:0] MAX_LEN_BYTE = 8'h1c;
  localparam logic [2:0] STATUS_WORD_IDX = 3'h7;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_CMD = 12'h004;
  localparam logic [11:0] A_RX_STATUS = 12'h008;
  localparam logic [11:0] A_EVENT = 12'h00c;
  localparam logic [3:0] BUF_PAGE = 4'h1;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_MFR_BIT = 0;
  localparam int unsigned CMD_START_BIT = 0;
  localparam int unsigned CMD_IDLE_BIT = 1;
  localparam int unsigned STAT_NFR_LSB = 0;
  localparam int unsigned STAT_ST_LSB = 8;
  localparam int unsigned EVT_RX_BIT = 0;
  localparam int unsigned SW_CNT_LSB = 0;
  localparam int unsigned SW_PAYLOAD_BIT = 8;
  localparam int unsigned SW_SHORT_BIT = 9;
  localparam int unsigned SW_COLL_BIT = 10;
  localparam int unsigned SW_COMB_BIT = 11;
  localparam int unsigned SW_LEN_BIT = 12;
  localparam int unsigned ST_WAIT_SEND_BIT = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_recv = 5'h02,
    st_gap = 5'h04,
    st_write_status = 5'h08,
    st_wait_send = 5'h10
  } rx_state_t;

endpackage

/* File: tb/card_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Card answering in polling timeslots
// ----------------------------------------
module card_model (
  input wire logic aclk,
  input wire logic rx_enable,
  output logic [7:0] rx_byte,
  output logic rx_byte_valid,
  output logic rx_frame_end,
  output logic rx_crc_ok,
  output logic rx_collision
);
  int gap = 0;

  initial begin
    rx_byte = 8'h5a;
    rx_byte_valid = 1'b0;
    rx_frame_end = 1'b0;
    rx_crc_ok = 1'b0;
    rx_collision = 1'b1;
  end

  // Answers only into an open slot; pace stretches byte spacing
  task automatic send(input logic [7:0] len, input int nb, input logic crc,
                      input logic coll, input int seq, input int pace);
    while (rx_enable !== 1'b1) @(posedge aclk);
    for (int i = 0; i < nb; i++) begin
      rx_byte <= (i == 0) ? len : 8'(i + seq * 32);
      rx_byte_valid <= 1'b1;
      @(posedge aclk);
      if (pace > 0) begin
        rx_byte_valid <= 1'b0;
        // Idle line shows the inverse, never a stale byte
        rx_byte <= ~rx_byte;
        repeat (pace) @(posedge aclk);
      end
    end
    rx_byte_valid <= 1'b0;
    rx_frame_end <= 1'b1;
    rx_crc_ok <= crc;
    rx_collision <= coll;
    @(posedge aclk);
    rx_frame_end <= 1'b0;
    rx_crc_ok <= ~crc;
    rx_collision <= ~coll;
    rx_byte <= ~rx_byte;
    gap = 0;
    // Bounded: in single mode the slot never reopens
    do begin
      @(posedge aclk);
      gap++;
    end while (rx_enable !== 1'b1 && gap < 100);
  endtask
endmodule // card_model

/* File: tb/testbench.sv */
`timescale 1ns/1ps

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
  mismatches++; $display("BAD %0t got %h exp %h", $time, got, exp); end end

module testbench;
  import mfr_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, rx_enable, wait_send;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [7:0] rx_byte;
  logic rx_byte_valid, rx_frame_end, rx_crc_ok, rx_collision;
  int mismatches = 0, n_tests = 0, cyc = 0;
  // Frame table: good, integrity, overlong, short, collision, full
  logic [7:0] f_len [8] = '{8'h03, 8'h04, 8'h1d, 8'h05, 8'h03, 8'h1c,
                            8'h03, 8'h03};
  int f_nb [8] = '{3, 4, 29, 2, 3, 28, 3, 3};
  logic [7:0] f_crc = 8'hfd;
  logic [7:0] f_col = 8'h10;
  logic [31:0] f_st [8] = '{32'h3, 32'h904, 32'h101d, 32'h1a02, 32'hc03,
                            32'h1c, 32'h3, 32'h3};

  always #12.5 aclk = ~aclk;

  multi_frame_rx_buffer dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
    .rx_frame_end(rx_frame_end), .rx_crc_ok(rx_crc_ok),
    .rx_collision(rx_collision), .rx_enable(rx_enable),
    .wait_send(wait_send));

  card_model card (.aclk(aclk), .rx_enable(rx_enable), .rx_byte(rx_byte),
    .rx_byte_valid(rx_byte_valid), .rx_frame_end(rx_frame_end),
    .rx_crc_ok(rx_crc_ok), .rx_collision(rx_collision));

  // ----------------------------------------
  // Bus access tasks
  // ----------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] v,
                    output logic [1:0] rs);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] s;
    rd(a, v, s);
    `CHK({s, v}, {RESP_OKAY, e})
  endtask

  task automatic complete_run;
    if (mismatches == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles needed
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      complete_run;
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(A_CTRL, 32'h0);
    rchk(A_RX_STATUS, 32'h100);
    rd(12'h020, d, r);
    `CHK({r, d}, {RESP_SLVERR, 32'h0})
    wr(A_RX_STATUS, 32'hf, r);
    rchk(A_RX_STATUS, 32'h100);
    wr(12'h040, 32'h1, r);
    `CHK(r, RESP_SLVERR)
    wr(A_CTRL, 32'h1, r);
    rchk(A_CTRL, 32'h1);
    wr(A_CMD, 32'h1, r);
    for (int n = 0; n < 8; n++) begin
      card.send(f_len[n], f_nb[n], f_crc[n], f_col[n], n, n % 2);
      if (n < 7) `CHK(card.gap >= GAP_CYCLES && card.gap <= 80, 1'b1)
      rchk(A_EVENT, 32'h1);
      wr(A_EVENT, 32'h1, r);
      rchk(A_EVENT, 32'h0);
      rchk(A_RX_STATUS, (n < 7) ? 32'(12'h200 + n + 1) : 32'h1008);
    end
    `CHK({wait_send, rx_enable}, 2'b10)
    for (int n = 0; n < 8; n++) rchk(12'h11c + 12'(32 * n), f_st[n]);
    rd(12'h100, d, r);
    `CHK(d[23:0], 24'h020103)
    rd(12'h1e0, d, r);
    `CHK(d[23:0], 24'he2e103)
    rchk(12'h1b8, 32'hbbbab9b8);
    wr(A_CTRL, 32'h0, r);
    wr(A_CMD, 32'h1, r);
    rchk(A_RX_STATUS, 32'h200);
    card.send(8'h03, 3, 1'b1, 1'b0, 0, 0);
    `CHK({wait_send, rx_enable}, 2'b10)
    rchk(A_RX_STATUS, 32'h1001);
    wr(A_CTRL, 32'h1, r);
    wr(A_CMD, 32'h1, r);
    // Event left unread, host times out
    card.send(8'h03, 3, 1'b1, 1'b0, 1, 0);
    wr(A_CMD, 32'h2, r);
    `CHK({wait_send, rx_enable}, 2'b00)
    rchk(A_RX_STATUS, 32'h101);
    complete_run;
  end
endmodule // testbench
